// ==== inc/ddrim_pkg.sv ====
// Constants, register map and types of the DDR init-mode and ECC syndrome block.
// Assumes an APB slave with 32-bit data, one clock pclk at 25 MHz, reset presetn.
package ddrim_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index.
	localparam logic [9:0] DDRIM_IDX_MODE = 10'h07C;
	localparam logic [9:0] DDRIM_IDX_SYNDROME = 10'h086;
	localparam logic [9:0] DDRIM_IDX_ERR_ADDR = 10'h08C;
	localparam logic [9:0] DDRIM_IDX_ERR_FLAG = 10'h024;
	localparam logic [9:0] DDRIM_IDX_IRQ_MASK = 10'h025;

	////////////////////////////////////////////////////////////////////////////
	// Field positions and values.
	localparam int DDRIM_MODE_LSB = 4;
	localparam logic [2:0] DDRIM_MODE_RESET = 3'h0;
	localparam logic [1:0] DDRIM_KIND_DDR = 2'h1;
	localparam logic [7:0] DDRIM_SYNDROME_RESET = 8'h00;
	localparam int DDRIM_FLAG_SBE = 0;
	localparam int DDRIM_FLAG_MBE = 1;
	localparam int DDRIM_FLAG_SR_ENTER = 2;
	localparam int DDRIM_FLAG_SR_EXIT = 3;
	localparam int DDRIM_FLAG_W = 4;
	localparam logic [3:0] DDRIM_FLAG_RESET = 4'h0;
	localparam logic [3:0] DDRIM_MASK_RESET = 4'h0;
	localparam int DDRIM_CKE_W = 4;
	localparam logic [12:0] DDRIM_EMRS_BANK = 13'h0000;
	localparam logic [1:0] DDRIM_BANK_MRS = 2'h0;
	localparam logic [1:0] DDRIM_BANK_EMRS = 2'h1;

	////////////////////////////////////////////////////////////////////////////
	// Initialization command modes.
	typedef enum logic [2:0] {
		DDRIM_MODE_POST_RESET = 3'b000,
		DDRIM_MODE_NOP = 3'b001,
		DDRIM_MODE_PRECHARGE = 3'b010,
		DDRIM_MODE_MRS = 3'b011,
		DDRIM_MODE_EMRS = 3'b100,
		DDRIM_MODE_RESERVED = 3'b101,
		DDRIM_MODE_REFRESH = 3'b110,
		DDRIM_MODE_NORMAL = 3'b111
	} ddrim_mode_type;

	// Commands placed on the memory interface.
	typedef enum logic [3:0] {
		DDRIM_CMD_NOP = 4'h0,
		DDRIM_CMD_PRECHARGE_ALL = 4'h1,
		DDRIM_CMD_MRS = 4'h2,
		DDRIM_CMD_EMRS = 4'h3,
		DDRIM_CMD_REFRESH = 4'h4,
		DDRIM_CMD_READ = 4'h5,
		DDRIM_CMD_WRITE = 4'h6,
		DDRIM_CMD_SR_ENTER = 4'h7,
		DDRIM_CMD_SR_EXIT = 4'h8
	} ddrim_cmd_type;

	// Power sequencing states.
	typedef enum logic [1:0] {
		DDRIM_ST_RUN = 2'b00,
		DDRIM_ST_FLUSH = 2'b01,
		DDRIM_ST_SELF_REFRESH = 2'b10,
		DDRIM_ST_EXIT = 2'b11
	} ddrim_state_type;

endpackage : ddrim_pkg

// ==== hdl/ddrim_ctrl.sv ====
// DDR init-mode command translation, clock-enable sequencing and ECC syndrome capture.
// Assumes an APB master on pclk, a host port that holds host_req until host_ack,
// and an ECC checker that pulses ecc_err_valid once per failing 32-byte unit.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps

module ddrim_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic host_req,
	input wire logic host_write,
	input wire logic [33:0] host_addr,
	output logic host_ack,
	output logic mem_cmd_valid,
	output ddrim_pkg::ddrim_cmd_type mem_cmd,
	output logic [12:0] memory_address_lines,
	output logic [1:0] mem_bank,
	output logic [3:0] mem_cke,
	input wire logic pending_cmds,
	input wire logic suspend_req,
	input wire logic lowpower_req,
	input wire logic ecc_err_valid,
	input wire logic ecc_err_multi,
	input wire logic [7:0] ecc_syndrome,
	input wire logic [33:5] ecc_err_addr,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations.
	logic [2:0] mode_q;
	logic cke_armed_q;
	logic [3:0] cke_q;
	logic suspended_q;
	ddrim_pkg::ddrim_state_type state_q;
	logic [7:0] syndrome_q;
	logic [33:5] err_addr_q;
	logic [3:0] flag_q;
	logic [3:0] mask_q;
	logic [31:0] prdata_q;
	logic err_q;
	logic ack_q;
	logic cmd_valid_q;
	ddrim_pkg::ddrim_cmd_type cmd_q;
	logic [12:0] addr_q;
	logic [1:0] bank_q;
	logic wr_en;
	logic rd_setup;
	logic [9:0] idx;
	logic mapped;
	logic mode_wr;
	logic [3:0] flag_clr;
	logic [3:0] flag_set;
	logic issue;
	logic sr_enter;
	logic sr_exit;
	logic locked;
	logic load_err;

	function automatic logic idx_mapped(input logic [9:0] i);
		idx_mapped = (i == ddrim_pkg::DDRIM_IDX_MODE) || (i == ddrim_pkg::DDRIM_IDX_SYNDROME) ||
			(i == ddrim_pkg::DDRIM_IDX_ERR_ADDR) || (i == ddrim_pkg::DDRIM_IDX_ERR_FLAG) ||
			(i == ddrim_pkg::DDRIM_IDX_IRQ_MASK);
	endfunction : idx_mapped

	////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, read data captured in the setup cycle.
	assign idx = paddr[11:2];
	assign mapped = idx_mapped(idx);
	assign wr_en = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable;
	assign mode_wr = wr_en && (idx == ddrim_pkg::DDRIM_IDX_MODE);
	assign flag_clr = (wr_en && (idx == ddrim_pkg::DDRIM_IDX_ERR_FLAG)) ? pwdata[3:0] : 4'h0;
	assign pready = psel && penable;
	assign pslverr = psel && penable && err_q;
	assign prdata = prdata_q;
	// Read data is taken in the setup cycle, so a read never mixes with a write of the same cycle.

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
			err_q <= 1'b0;
		end else if (rd_setup) begin
			err_q <= !mapped;
			prdata_q <= 32'h00000000;
			case (idx)
				ddrim_pkg::DDRIM_IDX_MODE: begin
					prdata_q <= {25'h0000000, mode_q, 2'h0, ddrim_pkg::DDRIM_KIND_DDR};
				end
				ddrim_pkg::DDRIM_IDX_SYNDROME: begin
					prdata_q <= {24'h000000, syndrome_q};
				end
				ddrim_pkg::DDRIM_IDX_ERR_ADDR: begin
					prdata_q <= {2'h0, err_addr_q, 1'b0};
				end
				ddrim_pkg::DDRIM_IDX_ERR_FLAG: begin
					prdata_q <= {28'h0000000, flag_q};
				end
				ddrim_pkg::DDRIM_IDX_IRQ_MASK: begin
					prdata_q <= {28'h0000000, mask_q};
				end
				default: begin
					prdata_q <= 32'h00000000;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode field and clock enables.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= ddrim_pkg::DDRIM_MODE_RESET;
		end else if (mode_wr) begin
			mode_q <= pwdata[ddrim_pkg::DDRIM_MODE_LSB +: 3];
		end
	end

	// Clock enables stand high during reset and drop at the first edge after release.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cke_armed_q <= 1'b0;
			cke_q <= '1;
		end else begin
			if (mode_wr && (pwdata[ddrim_pkg::DDRIM_MODE_LSB +: 3] != ddrim_pkg::DDRIM_MODE_RESET)) begin
				cke_armed_q <= 1'b1;
			end
			if (sr_enter) begin
				cke_q <= '0;
			end else if (sr_exit) begin
				cke_q <= '1;
			end else if (!cke_armed_q && !(mode_wr &&
				(pwdata[ddrim_pkg::DDRIM_MODE_LSB +: 3] != ddrim_pkg::DDRIM_MODE_RESET))) begin
				cke_q <= '0;
			end else if (state_q == ddrim_pkg::DDRIM_ST_RUN) begin
				cke_q <= '1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power sequencing: flush, self-refresh, and automatic exit from low power.
	assign sr_enter = (state_q == ddrim_pkg::DDRIM_ST_FLUSH) && !pending_cmds;
	assign sr_exit = (state_q == ddrim_pkg::DDRIM_ST_SELF_REFRESH) && !suspended_q && !lowpower_req;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ddrim_pkg::DDRIM_ST_RUN;
			suspended_q <= 1'b0;
		end else begin
			case (state_q)
				ddrim_pkg::DDRIM_ST_RUN: begin
					if (suspend_req || lowpower_req) begin
						state_q <= ddrim_pkg::DDRIM_ST_FLUSH;
						suspended_q <= suspend_req;
					end
				end
				ddrim_pkg::DDRIM_ST_FLUSH: begin
					if (sr_enter) begin
						state_q <= ddrim_pkg::DDRIM_ST_SELF_REFRESH;
					end
				end
				ddrim_pkg::DDRIM_ST_SELF_REFRESH: begin
					// Suspend is left only through reset on resume.
					if (sr_exit) begin
						state_q <= ddrim_pkg::DDRIM_ST_EXIT;
					end
				end
				ddrim_pkg::DDRIM_ST_EXIT: begin
					state_q <= ddrim_pkg::DDRIM_ST_RUN;
				end
				default: begin
					state_q <= ddrim_pkg::DDRIM_ST_RUN;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Host access translation; one command per accepted access, none in the post-reset and reserved modes.
	// Accesses are held off while any power request stands, so no command slips into a flush.
	assign issue = host_req && !ack_q && (state_q == ddrim_pkg::DDRIM_ST_RUN) &&
		!suspend_req && !lowpower_req;
	assign host_ack = ack_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_q <= 1'b0;
			cmd_valid_q <= 1'b0;
			cmd_q <= ddrim_pkg::DDRIM_CMD_NOP;
			addr_q <= 13'h0000;
			bank_q <= 2'h0;
		end else begin
			ack_q <= issue;
			cmd_valid_q <= 1'b0;
			if (sr_enter) begin
				cmd_valid_q <= 1'b1;
				cmd_q <= ddrim_pkg::DDRIM_CMD_SR_ENTER;
			end else if (sr_exit) begin
				cmd_valid_q <= 1'b1;
				cmd_q <= ddrim_pkg::DDRIM_CMD_SR_EXIT;
			end else if (issue) begin
				cmd_valid_q <= 1'b1;
				addr_q <= host_addr[15:3];
				bank_q <= ddrim_pkg::DDRIM_BANK_MRS;
				case (mode_q)
					ddrim_pkg::DDRIM_MODE_NOP: begin
						cmd_q <= ddrim_pkg::DDRIM_CMD_NOP;
					end
					ddrim_pkg::DDRIM_MODE_PRECHARGE: begin
						cmd_q <= ddrim_pkg::DDRIM_CMD_PRECHARGE_ALL;
					end
					ddrim_pkg::DDRIM_MODE_MRS: begin
						cmd_q <= ddrim_pkg::DDRIM_CMD_MRS;
					end
					ddrim_pkg::DDRIM_MODE_EMRS: begin
						cmd_q <= ddrim_pkg::DDRIM_CMD_EMRS;
						bank_q <= ddrim_pkg::DDRIM_BANK_EMRS;
					end
					ddrim_pkg::DDRIM_MODE_REFRESH: begin
						cmd_q <= ddrim_pkg::DDRIM_CMD_REFRESH;
					end
					ddrim_pkg::DDRIM_MODE_NORMAL: begin
						cmd_q <= host_write ? ddrim_pkg::DDRIM_CMD_WRITE : ddrim_pkg::DDRIM_CMD_READ;
					end
					default: begin
						// Post-reset and reserved codes complete the access with no command.
						cmd_valid_q <= 1'b0;
					end
				endcase
			end
		end
	end

	assign mem_cmd_valid = cmd_valid_q;
	assign mem_cmd = cmd_q;
	assign memory_address_lines = addr_q;
	assign mem_bank = bank_q;
	assign mem_cke = cke_q;

	////////////////////////////////////////////////////////////////////////////
	// ECC capture: first error locks, a multi-bit error may replace a single-bit one.
	assign locked = flag_q[ddrim_pkg::DDRIM_FLAG_SBE] || flag_q[ddrim_pkg::DDRIM_FLAG_MBE];
	assign load_err = ecc_err_valid && (!locked ||
		(ecc_err_multi && !flag_q[ddrim_pkg::DDRIM_FLAG_MBE]));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			syndrome_q <= ddrim_pkg::DDRIM_SYNDROME_RESET;
			err_addr_q <= '0;
		end else if (load_err) begin
			syndrome_q <= ecc_syndrome;
			err_addr_q <= ecc_err_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky event flags, write one to clear; a set in the same cycle wins.
	// Flags are set even while the capture is locked, so later errors stay visible to software.
	assign flag_set = {sr_exit, sr_enter, ecc_err_valid && ecc_err_multi, ecc_err_valid && !ecc_err_multi};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= ddrim_pkg::DDRIM_FLAG_RESET;
		end else begin
			flag_q <= (flag_q & ~flag_clr) | flag_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= ddrim_pkg::DDRIM_MASK_RESET;
		end else if (wr_en && (idx == ddrim_pkg::DDRIM_IDX_IRQ_MASK)) begin
			mask_q <= pwdata[3:0];
		end
	end

	assign irq = |(flag_q & mask_q);

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	cke_low_after_reset_a: assert property ($rose(presetn) |=> !cke_armed_q |-> mem_cke == 4'h0)
		else $error("Clock enables not low after reset release.");
	cke_on_write_a: assert property (mode_wr && pwdata[6:4] != 3'h0 && state_q == ddrim_pkg::DDRIM_ST_RUN
		&& !sr_exit |=> mem_cke == 4'hF)
		else $error("Clock enables not raised by nonzero mode write.");
	sr_entry_cke_a: assert property (sr_enter |=> mem_cke == 4'h0 && mem_cmd == ddrim_pkg::DDRIM_CMD_SR_ENTER)
		else $error("Self-refresh entry without clock enables low.");
	flush_wait_a: assert property (state_q == ddrim_pkg::DDRIM_ST_FLUSH && pending_cmds |=>
		state_q == ddrim_pkg::DDRIM_ST_FLUSH)
		else $error("Self-refresh entered with commands pending.");
	lowpower_exit_a: assert property (state_q == ddrim_pkg::DDRIM_ST_SELF_REFRESH && !suspended_q
		&& !lowpower_req |=> mem_cmd_valid && mem_cmd == ddrim_pkg::DDRIM_CMD_SR_EXIT ##1 mem_cke == 4'hF)
		else $error("Low-power exit not automatic.");
	nop_mode_a: assert property (issue && mode_q == 3'h1 |=>
		mem_cmd_valid && mem_cmd == ddrim_pkg::DDRIM_CMD_NOP && host_ack)
		else $error("NOP mode issued wrong command.");
	precharge_mode_a: assert property (issue && mode_q == 3'h2 |=>
		mem_cmd == ddrim_pkg::DDRIM_CMD_PRECHARGE_ALL)
		else $error("Precharge mode issued wrong command.");
	mrs_map_a: assert property (issue && mode_q == 3'h3 |=> mem_cmd == ddrim_pkg::DDRIM_CMD_MRS
		&& memory_address_lines == $past(host_addr[15:3]))
		else $error("Mode register set mapping wrong.");
	emrs_map_a: assert property (issue && mode_q == 3'h4 |=> mem_cmd == ddrim_pkg::DDRIM_CMD_EMRS
		&& memory_address_lines == $past(host_addr[15:3]))
		else $error("Extended mode register set mapping wrong.");
	refresh_mode_a: assert property (issue && mode_q == 3'h6 |=> mem_cmd == ddrim_pkg::DDRIM_CMD_REFRESH)
		else $error("Refresh mode issued wrong command.");
	syndrome_lock_a: assert property (locked && !load_err |=> $stable(syndrome_q) && $stable(err_addr_q))
		else $error("Syndrome changed while locked.");
	multi_overwrite_a: assert property (ecc_err_valid && ecc_err_multi && flag_q == 4'h1 |=>
		syndrome_q == $past(ecc_syndrome))
		else $error("Multi-bit error did not replace syndrome.");

	// Reset exit, command exclusivity, the read-only kind field and flag priority.
	mode_post_reset_a: assert property ($rose(presetn) |->
		mode_q == ddrim_pkg::DDRIM_MODE_RESET)
		else $error("Mode field not cleared at reset exit.");
	special_only_a: assert property (issue && mode_q != 3'h7 |=>
		!(mem_cmd_valid && (mem_cmd == ddrim_pkg::DDRIM_CMD_READ || mem_cmd == ddrim_pkg::DDRIM_CMD_WRITE)))
		else $error("Ordinary access issued in a special mode.");
	kind_code_a: assert property (pready && !pwrite && idx == ddrim_pkg::DDRIM_IDX_MODE |->
		prdata[1:0] == ddrim_pkg::DDRIM_KIND_DDR)
		else $error("Memory kind field read wrong.");
	flag_set_wins_a: assert property (ecc_err_valid && !ecc_err_multi |=>
		flag_q[ddrim_pkg::DDRIM_FLAG_SBE])
		else $error("Single-bit error flag lost to a clear.");

	init_seq_c: cover property (issue && mode_q == 3'h3 ##[1:20] issue && mode_q == 3'h7);
	lowpower_c: cover property (sr_enter ##[1:50] sr_exit);
	overwrite_c: cover property (load_err && !ecc_err_multi ##[1:20] load_err && ecc_err_multi);
	suspend_c: cover property (sr_enter && suspended_q);
	normal_write_c: cover property (issue && mode_q == 3'h7 && host_write);

endmodule : ddrim_ctrl

// ==== verification/ddrim_mem_model.sv ====
// Behavioural model of the DDR devices on the controller's command bus.
// Assumes one-cycle command strobes on pclk and clock enables that are all high or all low.
`timescale 1ns/100ps

module ddrim_mem_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mem_cmd_valid,
	input wire ddrim_pkg::ddrim_cmd_type mem_cmd,
	input wire logic [12:0] memory_address_lines,
	input wire logic [1:0] mem_bank,
	input wire logic [3:0] mem_cke,
	output ddrim_pkg::ddrim_cmd_type last_cmd,
	output logic [12:0] last_addr,
	output logic [1:0] last_bank,
	output logic [7:0] cmd_count,
	output logic [7:0] lost_count,
	output logic in_self_refresh
);
	logic accept;

	// A device latches nothing with its clock enable low, except the self-refresh entry itself.
	assign accept = (mem_cke == 4'hF) || (mem_cmd == ddrim_pkg::DDRIM_CMD_SR_ENTER && mem_cke == 4'h0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_cmd <= ddrim_pkg::DDRIM_CMD_NOP;
			last_addr <= 13'h0000;
			last_bank <= 2'h0;
			cmd_count <= 8'h00;
			lost_count <= 8'h00;
			in_self_refresh <= 1'b0;
		end else if (mem_cmd_valid && accept) begin
			last_cmd <= mem_cmd;
			last_addr <= memory_address_lines;
			last_bank <= mem_bank;
			cmd_count <= cmd_count + 8'h01;
			if (mem_cmd == ddrim_pkg::DDRIM_CMD_SR_ENTER) begin
				in_self_refresh <= 1'b1;
			end
			if (mem_cmd == ddrim_pkg::DDRIM_CMD_SR_EXIT) begin
				in_self_refresh <= 1'b0;
			end
		end else if (mem_cmd_valid) begin
			lost_count <= lost_count + 8'h01;
		end
	end
endmodule : ddrim_mem_model

// ==== verification/testbench.sv ====
// Self-checking bench of the DDR init-mode and ECC syndrome block.
// Assumes the design's zero-wait APB slave and the memory model beside it.
`timescale 1ns/100ps

`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("Error %s expected %h seen %h", n, e, g); end end

module testbench;
	localparam logic [11:0] A_MODE = {ddrim_pkg::DDRIM_IDX_MODE, 2'h0};
	localparam logic [11:0] A_SYN = {ddrim_pkg::DDRIM_IDX_SYNDROME, 2'h0};
	localparam logic [11:0] A_EA = {ddrim_pkg::DDRIM_IDX_ERR_ADDR, 2'h0};
	localparam logic [11:0] A_FLAG = {ddrim_pkg::DDRIM_IDX_ERR_FLAG, 2'h0};
	localparam logic [11:0] A_MASK = {ddrim_pkg::DDRIM_IDX_IRQ_MASK, 2'h0};
	localparam logic [33:0] HA = 34'h0_0001_5A78;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, host_req, host_write, host_ack, mem_cmd_valid;
	logic pending_cmds, suspend_req, lowpower_req, ecc_err_valid, ecc_err_multi, irq, in_sr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [33:0] host_addr;
	logic [12:0] memory_address_lines, last_addr;
	logic [1:0] mem_bank, last_bank;
	logic [3:0] mem_cke;
	logic [7:0] ecc_syndrome, cmd_count, lost_count;
	logic [33:5] ecc_err_addr;
	ddrim_pkg::ddrim_cmd_type mem_cmd, last_cmd;
	int failures, num_checks, cycles;

	ddrim_ctrl ddrim_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_req(host_req),
		.host_write(host_write), .host_addr(host_addr), .host_ack(host_ack), .mem_cmd_valid(mem_cmd_valid),
		.mem_cmd(mem_cmd), .memory_address_lines(memory_address_lines), .mem_bank(mem_bank), .mem_cke(mem_cke),
		.pending_cmds(pending_cmds), .suspend_req(suspend_req), .lowpower_req(lowpower_req),
		.ecc_err_valid(ecc_err_valid), .ecc_err_multi(ecc_err_multi), .ecc_syndrome(ecc_syndrome),
		.ecc_err_addr(ecc_err_addr), .irq(irq));
	ddrim_mem_model ddrim_mem_model_inst (.pclk(pclk), .presetn(presetn), .mem_cmd_valid(mem_cmd_valid),
		.mem_cmd(mem_cmd), .memory_address_lines(memory_address_lines), .mem_bank(mem_bank), .mem_cke(mem_cke),
		.last_cmd(last_cmd), .last_addr(last_addr), .last_bank(last_bank), .cmd_count(cmd_count),
		.lost_count(lost_count), .in_self_refresh(in_sr));

	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (failures == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic host(input logic w);
		@(posedge pclk);
		host_req <= 1'b1;
		host_write <= w;
		host_addr <= HA;
		@(posedge pclk);
		while (host_ack !== 1'b1) @(posedge pclk);
		host_req <= 1'b0;
		@(posedge pclk);
	endtask : host

	task automatic ecc(input logic m, input logic [7:0] s, input logic [28:0] a);
		@(posedge pclk);
		ecc_err_valid <= 1'b1;
		ecc_err_multi <= m;
		ecc_syndrome <= s;
		ecc_err_addr <= a;
		@(posedge pclk);
		ecc_err_valid <= 1'b0;
	endtask : ecc

	task automatic syn(input logic [7:0] s, input logic [28:0] a);
		apb(1'b0, A_SYN, 32'h0);
		`CHK("syndrome", s, rd[7:0])
		apb(1'b0, A_EA, 32'h0);
		`CHK("err_addr", {2'h0, a, 1'h0}, rd)
	endtask : syn

	task automatic wait_sr(input logic v);
		repeat (50) begin
			@(posedge pclk);
			if (in_sr === v) break;
		end
	endtask : wait_sr

	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		`CHK("cke_in_reset", 4'hF, mem_cke)
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		`CHK("cke_after_reset", 4'h0, mem_cke)
		apb(1'b0, A_MODE, 32'h0);
		`CHK("mode_after_reset", 32'h0000_0001, rd)
	endtask : do_reset

	task automatic mode_cmd(input logic [2:0] m, input ddrim_pkg::ddrim_cmd_type c, input logic [1:0] b,
		input logic [7:0] dn);
		logic [7:0] n0;
		apb(1'b1, A_MODE, {25'h0, m, 4'h2});
		apb(1'b0, A_MODE, 32'h0);
		`CHK("mode_rd", {25'h0, m, 4'h1}, rd)
		`CHK("cke_on", (m == 3'h0) ? 4'h0 : 4'hF, mem_cke)
		n0 = cmd_count;
		host(1'b0);
		`CHK("cmd_count", n0 + dn, cmd_count)
		if (dn != 8'h00) begin
			`CHK("cmd", c, last_cmd)
			`CHK("bank", b, last_bank)
		end
		if (m == 3'h3 || m == 3'h4) begin
			`CHK("addr", HA[15:3], last_addr)
		end
	endtask : mode_cmd

	////////////////////////////////////////////////////////////////////////////
	task automatic low_power();
		@(posedge pclk);
		pending_cmds <= 1'b1;
		lowpower_req <= 1'b1;
		repeat (4) @(posedge pclk);
		`CHK("cke_pending", 4'hF, mem_cke)
		pending_cmds <= 1'b0;
		wait_sr(1'b1);
		`CHK("sr_enter", ddrim_pkg::DDRIM_CMD_SR_ENTER, last_cmd)
		`CHK("cke_sr", 4'h0, mem_cke)
		lowpower_req <= 1'b0;
		wait_sr(1'b0);
		`CHK("sr_exit", ddrim_pkg::DDRIM_CMD_SR_EXIT, last_cmd)
		`CHK("cke_exit", 4'hF, mem_cke)
		apb(1'b0, A_FLAG, 32'h0);
		`CHK("flags", 4'hC, rd[3:0])
		apb(1'b1, A_MASK, 32'h4);
		#1;
		`CHK("irq_on", 1'b1, irq)
		apb(1'b1, A_MASK, 32'h0);
		#1;
		`CHK("irq_masked", 1'b0, irq)
		apb(1'b1, A_MASK, 32'h4);
		apb(1'b1, A_FLAG, 32'hC);
		#1;
		`CHK("irq_clear", 1'b0, irq)
		mode_cmd(3'h7, ddrim_pkg::DDRIM_CMD_READ, 2'h0, 8'h01);
	endtask : low_power

	task automatic ecc_test();
		syn(8'h00, 29'h0);
		ecc(1'b0, 8'h11, 29'h0AAAAAAA);
		syn(8'h11, 29'h0AAAAAAA);
		ecc(1'b0, 8'h22, 29'h15555555);
		syn(8'h11, 29'h0AAAAAAA);
		ecc(1'b1, 8'h33, 29'h01234567);
		syn(8'h33, 29'h01234567);
		ecc(1'b1, 8'h44, 29'h07654321);
		apb(1'b1, A_SYN, 32'hFF);
		syn(8'h33, 29'h01234567);
		apb(1'b1, A_FLAG, 32'h3);
		ecc(1'b1, 8'h55, 29'h00F0F0F0);
		syn(8'h55, 29'h00F0F0F0);
		apb(1'b0, 12'hFFC, 32'h0);
		`CHK("unmapped_err", 1'b1, err)
		`CHK("unmapped_data", 32'h0, rd)
	endtask : ecc_test

	task automatic suspend_test();
		@(posedge pclk);
		suspend_req <= 1'b1;
		wait_sr(1'b1);
		`CHK("susp_cmd", ddrim_pkg::DDRIM_CMD_SR_ENTER, last_cmd)
		suspend_req <= 1'b0;
		repeat (4) @(posedge pclk);
		`CHK("susp_cke", 4'h0, mem_cke)
		do_reset();
	endtask : suspend_test

	////////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	initial begin
		{presetn, psel, penable, pwrite, host_req, host_write, pending_cmds, suspend_req} = 8'h00;
		{lowpower_req, ecc_err_valid, ecc_err_multi} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		host_addr = 34'h0;
		ecc_syndrome = 8'h00;
		ecc_err_addr = 29'h0;
		do_reset();
		mode_cmd(3'h0, ddrim_pkg::DDRIM_CMD_NOP, 2'h0, 8'h00);
		`CHK("cke_mode0", 4'h0, mem_cke)
		mode_cmd(3'h1, ddrim_pkg::DDRIM_CMD_NOP, 2'h0, 8'h01);
		mode_cmd(3'h2, ddrim_pkg::DDRIM_CMD_PRECHARGE_ALL, 2'h0, 8'h01);
		mode_cmd(3'h3, ddrim_pkg::DDRIM_CMD_MRS, ddrim_pkg::DDRIM_BANK_MRS, 8'h01);
		mode_cmd(3'h4, ddrim_pkg::DDRIM_CMD_EMRS, ddrim_pkg::DDRIM_BANK_EMRS, 8'h01);
		mode_cmd(3'h6, ddrim_pkg::DDRIM_CMD_REFRESH, 2'h0, 8'h01);
		mode_cmd(3'h5, ddrim_pkg::DDRIM_CMD_NOP, 2'h0, 8'h00);
		mode_cmd(3'h7, ddrim_pkg::DDRIM_CMD_READ, 2'h0, 8'h01);
		host(1'b1);
		`CHK("cmd_write", ddrim_pkg::DDRIM_CMD_WRITE, last_cmd)
		low_power();
		ecc_test();
		`CHK("lost_cmds_pre", 8'h00, lost_count)
		suspend_test();
		mode_cmd(3'h1, ddrim_pkg::DDRIM_CMD_NOP, 2'h0, 8'h01);
		`CHK("lost_cmds", 8'h00, lost_count)
		print_verdict();
	end
endmodule : testbench
